// ---- fsp_defs.svh ----
// Constants for the flash self-programming controller and its core end.
// Assumes a 250 MHz system clock and a single synchronous reset.
//
// Operation
// - Boot size from two fuses: 128..1024 words
// - Boot start 0x1F80, 0x1F00, 0x1E00, 0x1C00
// - Words below 0x1C00 concurrent-read, rest stalling; every fetch stalls during programming here
// - Thirteen-bit word counter, bit 12 top
// - Sixty-four word pages, counter bits 5:0
// - Page index from pointer bits 13:7
// - Word index pointer 6:1; zero on write
// - Pointer offset one bit from counter
// - Pointer bits 15:14 always ignored
// - Pointer bit 0 zero; byte select loads
// - Poll command enable clear before new command
// - Wait for EEPROM write flag clear
// - Core masks interrupts around timed sequence
// - Read section blocked until re-enable command
// - Busy flag set while section unreadable
// - Enable alone stores r1:r0 into buffer
// - Store within four cycles or enables clear
// - Erase and write last 3.7 to 4.5 ms
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH

// ****************************************************************
// Control register bit positions
// ****************************************************************
`define FSP_BIT_ENABLE 0
`define FSP_BIT_ERASE 1
`define FSP_BIT_WRITE 2
`define FSP_BIT_REENABLE 4
`define FSP_BIT_BUSY 6
`define FSP_CTRL_RESET 8'h00

// ****************************************************************
// Address map
// ****************************************************************
`define FSP_BOOT_128 13'h1F80
`define FSP_BOOT_256 13'h1F00
`define FSP_BOOT_512 13'h1E00
`define FSP_BOOT_1024 13'h1C00
`define FSP_STALL_START 13'h1C00
`define FSP_BOOT_WORDS_MIN 11'h080

// ****************************************************************
// Timing
// ****************************************************************
`define FSP_CLK_MHZ 250
`define FSP_PROG_MIN_US 3700
`define FSP_PROG_MAX_US 4500
`define FSP_PROG_CYCLES (`FSP_PROG_MIN_US * `FSP_CLK_MHZ)
`define FSP_ARM_WINDOW 4

// ****************************************************************
// Avalon register offsets of the core end (word index)
// ****************************************************************
`define FSP_REG_CMD 2'h0
`define FSP_REG_ADDR 2'h1
`define FSP_REG_DATA 2'h2
`define FSP_REG_STATUS 2'h3

`endif

// ---- fsp_pkg.sv ----
// Types shared by both ends of the self-programming link.
// Assumes fsp_defs.svh holds the numeric constants.
package fsp_pkg;
  typedef enum logic [1:0] {
    FSP_OP_FILL = 2'b00,
    FSP_OP_ERASE = 2'b01,
    FSP_OP_WRITE = 2'b10,
    FSP_OP_REEN = 2'b11
  } fsp_op_type;
  typedef enum logic [1:0] {
    FSP_ST_IDLE = 2'b00,
    FSP_ST_ARMED = 2'b01,
    FSP_ST_PROG = 2'b10
  } fsp_state_type;
  typedef enum logic [2:0] {
    FSP_CS_IDLE = 3'b000,
    FSP_CS_POLL = 3'b001,
    FSP_CS_EEWAIT = 3'b010,
    FSP_CS_CTRL = 3'b011,
    FSP_CS_STORE = 3'b100
  } fsp_core_state_type;
endpackage : fsp_pkg

// ---- fsp_if.sv ----
// Link between the core end and the self-programming controller.
// Assumes both ends share I_REF_CLK.
`timescale 1ns/1ps
interface fsp_if;
  logic ctrl_wr;
  logic [7:0] ctrl_wdata;
  logic [7:0] ctrl_rdata;
  logic store;
  logic [15:0] pointer;
  logic [15:0] store_data;
  logic load;
  logic [7:0] load_data;
  logic eeprom_write_flag;
  modport ctrl (input ctrl_wr, input ctrl_wdata, output ctrl_rdata,
    input store, input pointer, input store_data, input load,
    output load_data, input eeprom_write_flag);
  modport core (output ctrl_wr, output ctrl_wdata, input ctrl_rdata,
    output store, output pointer, output store_data, output load,
    input load_data, output eeprom_write_flag);
endinterface : fsp_if

// ---- fsp_ctrl.sv ----
// Flash self-programming controller: control register, page buffer,
// flash array model and section map. Assumes the core end keeps the
// poll and EEPROM-wait order before each control write.
//
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "fsp_defs.svh"
module fsp_ctrl #(
  parameter int PROG_CYCLES = `FSP_PROG_CYCLES,
  parameter int PAGE_WORDS = 64,
  parameter int FLASH_WORDS = 8192
) (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  // Boot size fuses
  input wire logic I_BOOT_SIZE_HIGH_FUSE,
  input wire logic I_BOOT_SIZE_LOW_FUSE,
  // Core link
  fsp_if.ctrl LINK,
  // Fetch side
  input wire logic [12:0] I_FETCH_ADDR,
  output logic [15:0] O_FETCH_DATA,
  output logic O_FETCH_STALL,
  output logic O_SECTION_BUSY_FLAG,
  output logic [12:0] O_BOOT_START
);
  import fsp_pkg::*;

  logic [15:0] flash_mem [FLASH_WORDS];
  logic [15:0] page_buf [PAGE_WORDS];
  fsp_state_type state_q;
  fsp_op_type op_q;
  logic [7:0] ctrl_q;
  logic [2:0] arm_cnt_q;
  logic [31:0] prog_cnt_q;
  logic [6:0] page_q;
  logic busy_q;
  logic [1:0] fuse_s1_q;
  logic [1:0] fuse_s2_q;
  logic [12:0] boot_start;
  logic [12:0] boot_start_q;
  logic [12:0] load_addr;
  logic load_blocked;
  logic fetch_blocked;
  logic [6:0] page_idx;
  logic [5:0] word_idx;
  logic prog_done;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  always_comb begin
    case (fuse_s2_q)
      2'b11: boot_start = `FSP_BOOT_128;
      2'b10: boot_start = `FSP_BOOT_256;
      2'b01: boot_start = `FSP_BOOT_512;
      default: boot_start = `FSP_BOOT_1024;
    endcase
  end
  // Registered so the boot start is a flop output like the other data.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET)
      boot_start_q <= `FSP_BOOT_1024;
    else
      boot_start_q <= boot_start;
  end
  assign O_BOOT_START = boot_start_q;

  // ****************************************************************
  // Fuse synchronisers
  // ****************************************************************
  // The fuses are pins, so they pass two flops before the decode; the
  // boot start follows a fuse change three clocks later.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      fuse_s1_q <= 2'h0;
      fuse_s2_q <= 2'h0;
    end else begin
      fuse_s1_q <= {I_BOOT_SIZE_HIGH_FUSE, I_BOOT_SIZE_LOW_FUSE};
      fuse_s2_q <= fuse_s1_q;
    end
  end

  // Bits 15:14 are never looked at; bit 0 is only the load byte select.
  assign page_idx = LINK.pointer[13:7];
  assign word_idx = LINK.pointer[6:1];
  assign prog_done = (state_q == FSP_ST_PROG) &&
                     (prog_cnt_q == 32'(PROG_CYCLES - 1));

  // ****************************************************************
  // Command sequencing
  // ****************************************************************
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      state_q <= FSP_ST_IDLE;
      ctrl_q <= `FSP_CTRL_RESET;
      op_q <= FSP_OP_FILL;
      arm_cnt_q <= 3'h0;
      prog_cnt_q <= 32'h0;
      page_q <= 7'h00;
    end else begin
      case (state_q)
        FSP_ST_IDLE: begin
          // An EEPROM write in progress refuses the command outright.
          if (LINK.ctrl_wr && LINK.ctrl_wdata[`FSP_BIT_ENABLE] &&
              !LINK.eeprom_write_flag) begin
            ctrl_q <= LINK.ctrl_wdata;
            arm_cnt_q <= 3'h0;
            state_q <= FSP_ST_ARMED;
            if (LINK.ctrl_wdata[`FSP_BIT_ERASE])
              op_q <= FSP_OP_ERASE;
            else if (LINK.ctrl_wdata[`FSP_BIT_WRITE])
              op_q <= FSP_OP_WRITE;
            else if (LINK.ctrl_wdata[`FSP_BIT_REENABLE])
              op_q <= FSP_OP_REEN;
            else
              op_q <= FSP_OP_FILL;
          end
        end
        FSP_ST_ARMED: begin
          if (LINK.store) begin
            if (op_q == FSP_OP_ERASE || op_q == FSP_OP_WRITE) begin
              page_q <= page_idx;
              prog_cnt_q <= 32'h0;
              state_q <= FSP_ST_PROG;
            end else begin
              ctrl_q <= `FSP_CTRL_RESET;
              state_q <= FSP_ST_IDLE;
            end
          end else if (arm_cnt_q == 3'(`FSP_ARM_WINDOW - 1)) begin
            // The store came too late, so the command is dropped.
            ctrl_q <= `FSP_CTRL_RESET;
            state_q <= FSP_ST_IDLE;
          end else begin
            arm_cnt_q <= arm_cnt_q + 3'h1;
          end
        end
        FSP_ST_PROG: begin
          prog_cnt_q <= prog_cnt_q + 32'h1;
          if (prog_done) begin
            ctrl_q <= `FSP_CTRL_RESET;
            state_q <= FSP_ST_IDLE;
          end
        end
        default: state_q <= FSP_ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Section busy flag
  // ****************************************************************
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET)
      busy_q <= 1'b0;
    else if (state_q == FSP_ST_ARMED && LINK.store &&
             (op_q == FSP_OP_ERASE || op_q == FSP_OP_WRITE))
      busy_q <= 1'b1;
    else if (state_q == FSP_ST_ARMED && LINK.store && op_q == FSP_OP_REEN)
      busy_q <= 1'b0;
  end
  assign O_SECTION_BUSY_FLAG = busy_q;

  // ****************************************************************
  // Page buffer and flash array
  // ****************************************************************
  always_ff @(posedge I_REF_CLK) begin
    if (state_q == FSP_ST_ARMED && LINK.store && op_q == FSP_OP_FILL)
      page_buf[word_idx] <= LINK.store_data;
  end

  // The array commits at the end of the programming time, the way a
  // real cell does, so a reader during the operation sees old data.
  always_ff @(posedge I_REF_CLK) begin
    if (prog_done) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        flash_mem[{page_q, 6'(i)}] <=
          (op_q == FSP_OP_ERASE) ? 16'hFFFF : page_buf[i];
      end
    end
  end

  // ****************************************************************
  // Read paths
  // ****************************************************************
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      O_FETCH_DATA <= 16'h0000;
      LINK.load_data <= 8'h00;
    end else begin
      if (!O_FETCH_STALL)
        O_FETCH_DATA <= flash_mem[I_FETCH_ADDR];
      if (LINK.load && !load_blocked)
        LINK.load_data <= LINK.pointer[0] ?
          flash_mem[load_addr][15:8] :
          flash_mem[load_addr][7:0];
    end
  end

  // Stalling section fetches wait for the operation; the read section
  // stays blocked until re-enabled.
  // Loads take the word from pointer bits 13:1 and the byte from bit 0.
  assign load_addr = LINK.pointer[13:1];
  assign load_blocked = busy_q && (load_addr < `FSP_STALL_START);
  assign fetch_blocked = busy_q &&
                         (I_FETCH_ADDR < `FSP_STALL_START);
  assign O_FETCH_STALL = (state_q == FSP_ST_PROG) || fetch_blocked;

  assign LINK.ctrl_rdata = {1'b0, busy_q, ctrl_q[5:0]};
endmodule : fsp_ctrl

// ---- fsp_core.sv ----
// Core end: takes commands over Avalon-MM and runs the timed
// self-programming sequence on the link. Assumes the same clock.
`timescale 1ns/1ps
`include "fsp_defs.svh"
module fsp_core (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  // Avalon-MM slave
  input wire logic [1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // EEPROM status from outside
  input wire logic I_EEPROM_WRITE_FLAG,
  // Link
  fsp_if.core LINK
);
  import fsp_pkg::*;

  fsp_core_state_type state_q;
  logic [7:0] cmd_q;
  logic [15:0] addr_q;
  logic [15:0] data_q;
  logic ee_s1_q;
  logic ee_s2_q;
  logic rd_done_q;
  logic accept;

  // ****************************************************************
  // Avalon slave
  // ****************************************************************
  // Writes to CMD wait while a sequence runs; reads answer next cycle.
  assign accept = I_AVS_WRITE && I_AVS_ADDRESS == `FSP_REG_CMD &&
                  state_q == FSP_CS_IDLE;
  assign O_AVS_WAITREQUEST = (I_AVS_READ && !rd_done_q) ||
    (I_AVS_WRITE && I_AVS_ADDRESS == `FSP_REG_CMD &&
     state_q != FSP_CS_IDLE);

  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      rd_done_q <= 1'b0;
      O_AVS_READDATA <= 32'h0;
    end else begin
      rd_done_q <= I_AVS_READ && !rd_done_q;
      case (I_AVS_ADDRESS)
        `FSP_REG_CMD: O_AVS_READDATA <= {24'h0, cmd_q};
        `FSP_REG_ADDR: O_AVS_READDATA <= {16'h0, addr_q};
        `FSP_REG_DATA: O_AVS_READDATA <= {16'h0, data_q};
        default: O_AVS_READDATA <= {23'h0, state_q != FSP_CS_IDLE,
                                    LINK.ctrl_rdata};
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      addr_q <= 16'h0;
      data_q <= 16'h0;
    end else if (I_AVS_WRITE && !O_AVS_WAITREQUEST) begin
      if (I_AVS_ADDRESS == `FSP_REG_ADDR)
        addr_q <= I_AVS_WRITEDATA[15:0];
      if (I_AVS_ADDRESS == `FSP_REG_DATA)
        data_q <= I_AVS_WRITEDATA[15:0];
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      ee_s1_q <= 1'b0;
      ee_s2_q <= 1'b0;
    end else begin
      ee_s1_q <= I_EEPROM_WRITE_FLAG;
      ee_s2_q <= ee_s1_q;
    end
  end

  // ****************************************************************
  // Timed sequence
  // ****************************************************************
  // Nothing here can be interrupted, so the timed pair is atomic.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      state_q <= FSP_CS_IDLE;
      cmd_q <= 8'h00;
    end else begin
      case (state_q)
        FSP_CS_IDLE: begin
          if (accept) begin
            cmd_q <= I_AVS_WRITEDATA[7:0];
            state_q <= FSP_CS_POLL;
          end
        end
        FSP_CS_POLL: begin
          if (!LINK.ctrl_rdata[`FSP_BIT_ENABLE])
            state_q <= FSP_CS_EEWAIT;
        end
        FSP_CS_EEWAIT: begin
          if (!ee_s2_q)
            state_q <= FSP_CS_CTRL;
        end
        FSP_CS_CTRL: state_q <= FSP_CS_STORE;
        FSP_CS_STORE: state_q <= FSP_CS_IDLE;
        default: state_q <= FSP_CS_IDLE;
      endcase
    end
  end

  assign LINK.ctrl_wr = (state_q == FSP_CS_CTRL);
  assign LINK.ctrl_wdata = cmd_q | 8'h01;
  assign LINK.store = (state_q == FSP_CS_STORE);
  // Word index is forced to zero for page write, bit 0 for all stores.
  assign LINK.pointer = LINK.store ?
    (cmd_q[`FSP_BIT_WRITE] ? {addr_q[15:7], 7'h00}
                           : {addr_q[15:1], 1'b0}) : addr_q;
  assign LINK.store_data = data_q;
  assign LINK.load = I_AVS_READ && I_AVS_ADDRESS == `FSP_REG_DATA;
  assign LINK.eeprom_write_flag = ee_s2_q;
endmodule : fsp_core

// ---- fsp_checker.sv ----
// Link checks between the core end and the controller.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "fsp_defs.svh"
module fsp_checker (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  // Link signals
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] ctrl_rdata,
  input wire logic store,
  input wire logic [15:0] pointer
);
  import fsp_pkg::*;
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RESET);
  sequence erase_seq;
    ctrl_wr && ctrl_wdata[`FSP_BIT_ERASE] ##1 store;
  endsequence
  sequence write_seq;
    ctrl_wr && ctrl_wdata[`FSP_BIT_WRITE] ##1 store;
  endsequence
  // A fill has neither erase, write nor re-enable set.
  sequence fill_seq;
    ctrl_wr && ctrl_wdata[2:1] == 2'h0 && !ctrl_wdata[4] ##1 store;
  endsequence
  a_store_in_window: assert property (
    ctrl_wr |-> ##[1:4] store) else $error("store late after control");
  a_pointer_bit0_zero: assert property (
    store |-> !pointer[0]) else $error("pointer bit 0 set on store");
  a_write_word_zero: assert property (
    write_seq |-> pointer[6:1] == 6'h00)
    else $error("word index not zero on page write");
  a_poll_enable_clear: assert property (
    ctrl_wr |-> !ctrl_rdata[`FSP_BIT_ENABLE])
    else $error("control written while enable set");
  a_enable_with_cmd: assert property (
    ctrl_wr |-> ctrl_wdata[`FSP_BIT_ENABLE])
    else $error("command without enable");
  a_erase_sets_busy: assert property (
    erase_seq |-> ##[1:4] ctrl_rdata[`FSP_BIT_BUSY])
    else $error("busy not set by erase");
  a_busy_clear_cause: assert property (
    $fell(ctrl_rdata[`FSP_BIT_BUSY]) |-> $past(store) || $past(store, 2))
    else $error("busy cleared without a store");
  a_fill_clears_enable: assert property (
    fill_seq |-> ##[1:2] !ctrl_rdata[`FSP_BIT_ENABLE])
    else $error("enable not cleared after fill");
  c_erase: cover property (erase_seq);
  c_write: cover property (write_seq);
  c_reen: cover property (ctrl_wr && ctrl_wdata[`FSP_BIT_REENABLE]);
endmodule : fsp_checker

// ---- flash_self_program_addressing_bench.sv ----
// Bench joining the core end and the controller over the link.
// Assumes the design files and fsp_checker compile first.
`timescale 1ns/1ps
`include "fsp_defs.svh"
module flash_self_program_addressing_bench;
  import fsp_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic fuse_h = 1'h1;
  logic fuse_l = 1'h1;
  logic [12:0] faddr = 13'h0000;
  logic [1:0] av_addr = 2'h0;
  logic av_rd = 1'h0;
  logic av_wr = 1'h0;
  logic [31:0] av_wdata = 32'h0;
  logic [31:0] av_rdata;
  logic av_wait;
  logic ee_flag = 1'h0;
  logic [15:0] fdata;
  logic stall;
  logic busy;
  logic [12:0] boot;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int wr_count = 0;
  fsp_if link ();
  // A short programming time keeps the run small.
  fsp_ctrl #(.PROG_CYCLES(20)) u_fsp_ctrl (.I_REF_CLK(clk), .I_RESET(rst),
    .I_BOOT_SIZE_HIGH_FUSE(fuse_h), .I_BOOT_SIZE_LOW_FUSE(fuse_l),
    .LINK(link), .I_FETCH_ADDR(faddr), .O_FETCH_DATA(fdata),
    .O_FETCH_STALL(stall), .O_SECTION_BUSY_FLAG(busy), .O_BOOT_START(boot));
  fsp_core u_fsp_core (.I_REF_CLK(clk), .I_RESET(rst),
    .I_AVS_ADDRESS(av_addr), .I_AVS_READ(av_rd), .I_AVS_WRITE(av_wr),
    .I_AVS_WRITEDATA(av_wdata), .O_AVS_READDATA(av_rdata),
    .O_AVS_WAITREQUEST(av_wait), .I_EEPROM_WRITE_FLAG(ee_flag), .LINK(link));
  fsp_checker u_fsp_checker (.I_REF_CLK(clk), .I_RESET(rst),
    .ctrl_wr(link.ctrl_wr), .ctrl_wdata(link.ctrl_wdata),
    .ctrl_rdata(link.ctrl_rdata), .store(link.store),
    .pointer(link.pointer));
  initial begin
    forever #2 clk = ~clk;
  end
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task close_out;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (link.ctrl_wr === 1'h1) begin
      wr_count <= wr_count + 1;
    end
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked = checked + 1;
    if (s !== e) begin
      mismatches = mismatches + 1;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic av_write(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    av_addr <= a;
    av_wdata <= d;
    av_wr <= 1'h1;
    @(posedge clk);
    while (av_wait !== 1'h0) @(posedge clk);
    av_wr <= 1'h0;
  endtask : av_write
  task automatic av_read(input logic [1:0] a, output logic [31:0] d);
    @(posedge clk);
    av_addr <= a;
    av_rd <= 1'h1;
    @(posedge clk);
    while (av_wait !== 1'h0) @(posedge clk);
    d = av_rdata;
    av_rd <= 1'h0;
  endtask : av_read
  task automatic wait_idle;
    logic [31:0] s;
    int n;
    n = 0;
    s = 32'h1;
    while ((s[8] | s[0]) !== 1'h0 && n < 200) begin
      av_read(`FSP_REG_STATUS, s);
      n++;
    end
    chk("sequence done", 32'(s[8] | s[0]), 32'h0);
  endtask : wait_idle
  task automatic run(input logic [7:0] c, input logic [15:0] p, d,
    input logic watch);
    int n;
    n = 0;
    av_write(`FSP_REG_ADDR, {16'h0, p});
    av_write(`FSP_REG_DATA, {16'h0, d});
    av_write(`FSP_REG_CMD, {24'h0, c});
    if (watch) begin
      while (busy !== 1'h1 && n < 40) begin
        @(posedge clk);
        n++;
      end
      faddr <= 13'h1C00;
      @(negedge clk);
      chk("stall in programming", 32'(stall), 32'h1);
    end
    wait_idle();
  endtask : run
  task automatic probe(input logic [12:0] a, input logic e);
    @(posedge clk);
    faddr <= a;
    @(negedge clk);
    chk("fetch stall", 32'(stall), 32'(e));
  endtask : probe
  task automatic fetch(input logic [12:0] a, input logic [15:0] e);
    @(posedge clk);
    faddr <= a;
    @(posedge clk);
    @(negedge clk);
    chk("fetch data", 32'(fdata), 32'(e));
  endtask : fetch
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_fuses;
    logic [12:0] exp [4];
    exp = '{13'h1C00, 13'h1E00, 13'h1F00, 13'h1F80};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      fuse_h <= i[1];
      fuse_l <= i[0];
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("boot start", 32'(boot), 32'(exp[i]));
      chk("boot words", 32'h2000 - 32'(boot), 32'h80 << (3 - i));
    end
  endtask : t_fuses
  task automatic t_erase;
    logic [31:0] s;
    run(8'h03, 16'hC280, 16'h0000, 1'h1);
    probe(13'h1BFF, 1'h1);
    probe(13'h1C00, 1'h0);
    chk("busy flag", 32'(busy), 32'h1);
    av_read(`FSP_REG_STATUS, s);
    chk("status busy", 32'(s[6]), 32'h1);
    run(8'h11, 16'h0000, 16'h0000, 1'h0);
    chk("busy after reenable", 32'(busy), 32'h0);
    probe(13'h1BFF, 1'h0);
    fetch(13'h0140, 16'hFFFF);
  endtask : t_erase
  task automatic t_program;
    logic [31:0] s;
    run(8'h01, 16'hC280, 16'hA5C3, 1'h0);
    run(8'h01, 16'hC282, 16'h5A3C, 1'h0);
    run(8'h01, 16'hC2FE, 16'h0F1E, 1'h0);
    run(8'h05, 16'hC2FE, 16'h0000, 1'h1);
    run(8'h11, 16'h0000, 16'h0000, 1'h0);
    fetch(13'h0140, 16'hA5C3);
    fetch(13'h0141, 16'h5A3C);
    fetch(13'h017F, 16'h0F1E);
    av_write(`FSP_REG_ADDR, 32'h0000C280);
    av_read(`FSP_REG_DATA, s);
    chk("load low byte", 32'(link.load_data), 32'hC3);
    av_write(`FSP_REG_ADDR, 32'h0000C281);
    av_read(`FSP_REG_DATA, s);
    chk("load high byte", 32'(link.load_data), 32'hA5);
    chk("data readback", s, 32'h0);
  endtask : t_program
  task automatic t_eeprom;
    logic [31:0] s;
    int w0;
    w0 = wr_count;
    ee_flag <= 1'h1;
    av_write(`FSP_REG_CMD, 32'h11);
    repeat (12) @(posedge clk);
    av_read(`FSP_REG_STATUS, s);
    chk("active while eeprom busy", 32'(s[8]), 32'h1);
    chk("control held off", 32'(wr_count), 32'(w0));
    ee_flag <= 1'h0;
    wait_idle();
    chk("control after eeprom", 32'(wr_count), 32'(w0 + 1));
  endtask : t_eeprom
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    t_fuses();
    t_erase();
    t_program();
    t_eeprom();
    close_out();
  end
endmodule : flash_self_program_addressing_bench
